// file: hdl/uiba_arbiter.sv
// uart interrupt bid arbiter top
// Function
// - identity code bits 6:3, channel bits 2:0
// - receiver x001/x101, transmitter xx00
// - break 0010, state 0110, xon 0111, address 0011
// - fifo count minus one in high bits
// - transmitter count one bit lower, bit9 zero
// - event sources take software priority bits
// - threshold is seven bits plus zero channel
// - request withdrawn when threshold beats all bids
// - channels 0..3, higher channel wins ties
// - winner identity code drives type output
// - threshold msb set blocks all transmitters
// - start levels keep fifos out of arbitration
// - timeout lets only enabled receivers bid
// - timeout forces threshold to zero
// - timeout has no identity code itself
// - zero-count transmitter needs threshold 0000000 and channel 1..3
// - new winner every 22 clocks, snapshot per scan
// - masked sources never request nor captured
// - threshold bit 6 aligns with bid bit 9
// - capture with no winner loads all zeros
`timescale 1ns/1ns
`default_nettype none
`include "uiba_defines.svh"
module uiba_arbiter (
    // clock, reset, enable
    input  wire  logic                                MCLK_I,
    input  wire  logic                                RST_N_I,
    input  wire  logic                                CE_I,
    // register port
    input  wire  logic [3:0]                          ADDR_I,
    input  wire  logic [31:0]                         WDATA_I,
    input  wire  logic                                WR_I,
    input  wire  logic                                RD_I,
    output logic [31:0]                               RDATA_O,
    // channel state
    input  wire  uiba_pkg::uiba_chan_t [`UIBA_NCH-1:0] CHAN_STAT_I,
    // host handshake
    input  wire  logic                                INTERRUPT_ACK_LOW_I,
    output logic                                      INTERRUPT_REQUEST_LOW_O,
    // current interrupt
    output logic [9:0]                                CIR_O,
    output logic [3:0]                                CIR_TYPE_O,
    output logic [2:0]                                CIR_CHAN_O
);
    // configuration registers
    logic [6:0]  interrupt_control_reg_ff;
    logic [6:0]  nxt_interrupt_control_reg;
    logic [31:0] interrupt_mask_reg_ff;
    logic [31:0] nxt_interrupt_mask_reg;
    logic [11:0] bid_priority_regs_ff;
    logic [11:0] nxt_bid_priority_regs;
    logic [7:0]  mode_reg_zero_ff;
    logic [7:0]  nxt_mode_reg_zero;
    logic [7:0]  mode_reg_two_ff;
    logic [7:0]  nxt_mode_reg_two;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        upd_wr;
    logic [9:0]  cir_ff;
    logic        win_vld_ff;
    logic        wd_used_ff;
    logic        irq_n_ff;

    always_comb begin
        nxt_interrupt_control_reg = interrupt_control_reg_ff;
        nxt_interrupt_mask_reg    = interrupt_mask_reg_ff;
        nxt_bid_priority_regs     = bid_priority_regs_ff;
        nxt_mode_reg_zero         = mode_reg_zero_ff;
        nxt_mode_reg_two          = mode_reg_two_ff;
        nxt_rdata                 = 32'h0000_0000;
        upd_wr                    = WR_I && (ADDR_I == `UIBA_A_CIR);
        if (WR_I) begin
            case (ADDR_I)
                `UIBA_A_ICR: nxt_interrupt_control_reg = WDATA_I[6:0];
                `UIBA_A_IMR: nxt_interrupt_mask_reg    = WDATA_I;
                `UIBA_A_BPR: nxt_bid_priority_regs     = WDATA_I[11:0];
                `UIBA_A_MR0: nxt_mode_reg_zero         = WDATA_I[7:0];
                `UIBA_A_MR2: nxt_mode_reg_two          = WDATA_I[7:0];
                default:     nxt_rdata                 = 32'h0000_0000;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                `UIBA_A_ICR:  nxt_rdata = {25'h000_0000, interrupt_control_reg_ff};
                `UIBA_A_IMR:  nxt_rdata = interrupt_mask_reg_ff;
                `UIBA_A_BPR:  nxt_rdata = {20'h0_0000, bid_priority_regs_ff};
                `UIBA_A_MR0:  nxt_rdata = {24'h00_0000, mode_reg_zero_ff};
                `UIBA_A_MR2:  nxt_rdata = {24'h00_0000, mode_reg_two_ff};
                `UIBA_A_CIR:  nxt_rdata = {22'h00_0000, cir_ff};
                `UIBA_A_STAT: nxt_rdata = {29'h0000_0000, wd_used_ff, !irq_n_ff, win_vld_ff};
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            interrupt_control_reg_ff <= `UIBA_RST_ICR;
            interrupt_mask_reg_ff    <= `UIBA_RST_IMR;
            bid_priority_regs_ff     <= `UIBA_RST_BPR;
            mode_reg_zero_ff         <= `UIBA_RST_LVL;
            mode_reg_two_ff          <= `UIBA_RST_LVL;
            rdata_ff                 <= 32'h0000_0000;
        end else if (CE_I) begin
            interrupt_control_reg_ff <= nxt_interrupt_control_reg;
            interrupt_mask_reg_ff    <= nxt_interrupt_mask_reg;
            bid_priority_regs_ff     <= nxt_bid_priority_regs;
            mode_reg_zero_ff         <= nxt_mode_reg_zero;
            mode_reg_two_ff          <= nxt_mode_reg_two;
            rdata_ff                 <= nxt_rdata;
        end
    end

    // bid sources, one builder per channel
    uiba_pkg::uiba_bid_t [`UIBA_NBID-1:0] live_bid;
    logic [`UIBA_NCH-1:0]                 wd_hit;
    logic                                 wd_mode;

    genvar gc;
    generate
        for (gc = 0; gc < `UIBA_NCH; gc++) begin : g_ch
            assign wd_hit[gc] = CHAN_STAT_I[gc].wdog
                                && interrupt_mask_reg_ff[gc*8 + `UIBA_M_WD];
            uiba_bid_gen u_uiba_bid_gen (
                .chan_i               (CHAN_STAT_I[gc]),
                .chan_no_i            (3'(gc)),
                .mask_i               (interrupt_mask_reg_ff[gc*8 +: 8]),
                .bid_priority_regs_i  (bid_priority_regs_ff),
                .tx_bid_start_level_i (mode_reg_zero_ff[gc*2 +: 2]),
                .rx_bid_start_level_i (mode_reg_two_ff[gc*2 +: 2]),
                .wd_mode_i            (wd_mode),
                .bid_o                (live_bid[gc*`UIBA_NSRC +: `UIBA_NSRC])
            );
        end
    endgenerate
    assign wd_mode = |wd_hit;

    // scan: snapshot at start, verdict at the last of 22 cycles
    logic [4:0]                           scan_cnt_ff;
    logic [4:0]                           nxt_scan_cnt;
    uiba_pkg::uiba_bid_t [`UIBA_NBID-1:0] snap_ff;
    uiba_pkg::uiba_bid_t [`UIBA_NBID-1:0] nxt_snap;
    logic [9:0]                           thr_snap_ff;
    logic [9:0]                           nxt_thr_snap;
    logic                                 wd_snap_ff;
    logic                                 nxt_wd_snap;
    logic [9:0]                           best;
    logic                                 best_vld;
    logic [9:0]                           win_ff;
    logic [9:0]                           nxt_win;
    logic                                 nxt_win_vld;
    logic [9:0]                           thr_used_ff;
    logic [9:0]                           nxt_thr_used;
    logic                                 nxt_wd_used;
    logic                                 nxt_irq_n;

    always_comb begin
        nxt_scan_cnt = (scan_cnt_ff == `UIBA_SCAN_LAST) ? `UIBA_SCAN_FIRST
                                                        : scan_cnt_ff + 5'h01;
        nxt_snap     = snap_ff;
        nxt_thr_snap = thr_snap_ff;
        nxt_wd_snap  = wd_snap_ff;
        if (scan_cnt_ff == `UIBA_SCAN_FIRST) begin
            // later arrivals wait for the next scan
            nxt_snap     = live_bid;
            nxt_wd_snap  = wd_mode;
            nxt_thr_snap = wd_mode ? 10'h000
                                   : {interrupt_control_reg_ff, 3'h0};
        end
        best     = 10'h000;
        best_vld = 1'b0;
        for (int i = 0; i < `UIBA_NBID; i++) begin
            // channel sits in the low bits, so ties go to the higher channel
            if (snap_ff[i].vld && (!best_vld || snap_ff[i].val > best)) begin
                best     = snap_ff[i].val;
                best_vld = 1'b1;
            end
        end
        nxt_win      = win_ff;
        nxt_win_vld  = win_vld_ff;
        nxt_thr_used = thr_used_ff;
        nxt_wd_used  = wd_used_ff;
        nxt_irq_n    = irq_n_ff;
        if (scan_cnt_ff == `UIBA_SCAN_LAST) begin
            nxt_win      = best;
            nxt_win_vld  = best_vld && (best > thr_snap_ff);
            nxt_thr_used = thr_snap_ff;
            nxt_wd_used  = wd_snap_ff;
            nxt_irq_n    = !(best_vld && (best > thr_snap_ff));
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            scan_cnt_ff <= `UIBA_SCAN_FIRST;
            snap_ff     <= '0;
            thr_snap_ff <= 10'h000;
            wd_snap_ff  <= 1'b0;
            win_ff      <= 10'h000;
            win_vld_ff  <= 1'b0;
            thr_used_ff <= 10'h000;
            wd_used_ff  <= 1'b0;
            irq_n_ff    <= 1'b1;
        end else if (CE_I) begin
            scan_cnt_ff <= nxt_scan_cnt;
            snap_ff     <= nxt_snap;
            thr_snap_ff <= nxt_thr_snap;
            wd_snap_ff  <= nxt_wd_snap;
            win_ff      <= nxt_win;
            win_vld_ff  <= nxt_win_vld;
            thr_used_ff <= nxt_thr_used;
            wd_used_ff  <= nxt_wd_used;
            irq_n_ff    <= nxt_irq_n;
        end
    end

    // current interrupt latch
    logic       ack_d_ff;
    logic       nxt_ack_d;
    logic       cap;
    logic [9:0] nxt_cir;

    always_comb begin
        nxt_ack_d = INTERRUPT_ACK_LOW_I;
        cap       = (ack_d_ff && !INTERRUPT_ACK_LOW_I) || upd_wr;
        nxt_cir   = cir_ff;
        if (cap) begin
            nxt_cir = win_vld_ff ? win_ff : `UIBA_RST_CIR;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ack_d_ff <= 1'b1;
            cir_ff   <= `UIBA_RST_CIR;
        end else if (CE_I) begin
            ack_d_ff <= nxt_ack_d;
            cir_ff   <= nxt_cir;
        end
    end

    assign INTERRUPT_REQUEST_LOW_O = irq_n_ff;
    assign CIR_O                   = cir_ff;
    assign CIR_TYPE_O              = cir_ff[6:3];
    assign CIR_CHAN_O              = cir_ff[2:0];
    assign RDATA_O                 = rdata_ff;

    // checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_capture;
        CE_I && cap;
    endsequence
    sequence s_scan_end;
        CE_I && scan_cnt_ff == `UIBA_SCAN_LAST;
    endsequence

    property p_scan_wrap;
        s_scan_end |=> scan_cnt_ff == `UIBA_SCAN_FIRST;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan not 22 cycles");

    property p_irq_at_scan;
        $changed(irq_n_ff) |-> $past(scan_cnt_ff) == `UIBA_SCAN_LAST;
    endproperty
    a_irq_at_scan: assert property (p_irq_at_scan) else $error("irq moved mid scan");

    property p_irq_above;
        !irq_n_ff |-> win_ff > thr_used_ff && win_vld_ff;
    endproperty
    a_irq_above: assert property (p_irq_above) else $error("irq without win");

    property p_irq_off;
        irq_n_ff |-> !win_vld_ff;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq off with winner");

    property p_tx_blocked;
        !irq_n_ff && thr_used_ff[9] |-> win_ff[9];
    endproperty
    a_tx_blocked: assert property (p_tx_blocked) else $error("tx passed msb");

    property p_wd_rx;
        !irq_n_ff && wd_used_ff |-> win_ff[4:3] == 2'h1 && thr_used_ff == 10'h000;
    endproperty
    a_wd_rx: assert property (p_wd_rx) else $error("non rx in timeout");

    property p_cir_zero;
        s_capture ##0 !win_vld_ff |=> cir_ff == `UIBA_RST_CIR;
    endproperty
    a_cir_zero: assert property (p_cir_zero) else $error("cir not cleared");

    property p_cir_load;
        s_capture ##0 win_vld_ff |=> cir_ff == $past(win_ff) && cir_ff[2:0] <= 3'h3;
    endproperty
    a_cir_load: assert property (p_cir_load) else $error("cir load wrong");

    property p_cir_hold;
        !(CE_I && cap) |=> $stable(cir_ff);
    endproperty
    a_cir_hold: assert property (p_cir_hold) else $error("cir moved");
endmodule : uiba_arbiter
`default_nettype wire

// file: hdl/uiba_defines.svh
// constants for the uart interrupt bid arbiter
`ifndef UIBA_DEFINES_SVH
`define UIBA_DEFINES_SVH

`define UIBA_NCH        4
`define UIBA_NSRC       6
`define UIBA_NBID       24
`define UIBA_SCAN_LAST  5'h15
`define UIBA_SCAN_FIRST 5'h00

`define UIBA_A_ICR      4'h0
`define UIBA_A_IMR      4'h1
`define UIBA_A_BPR      4'h2
`define UIBA_A_MR0      4'h3
`define UIBA_A_MR2      4'h4
`define UIBA_A_CIR      4'h5
`define UIBA_A_STAT     4'h6

`define UIBA_RST_ICR    7'h00
`define UIBA_RST_IMR    32'h0000_0000
`define UIBA_RST_BPR    12'h000
`define UIBA_RST_LVL    8'h00
`define UIBA_RST_CIR    10'h000

`define UIBA_LVL_ONE    5'h01
`define UIBA_LVL_HALF   5'h08
`define UIBA_LVL_3Q     5'h0C
`define UIBA_LVL_FULL   5'h10

`define UIBA_ID_RXOK    3'h1
`define UIBA_ID_RXERR   3'h5
`define UIBA_ID_TX      2'h0
`define UIBA_ID_BRK     4'h2
`define UIBA_ID_COS     4'h6
`define UIBA_ID_XON     4'h7
`define UIBA_ID_ADR     4'h3

`define UIBA_M_RX       0
`define UIBA_M_TX       1
`define UIBA_M_BRK      2
`define UIBA_M_COS      3
`define UIBA_M_XON      4
`define UIBA_M_ADR      5
`define UIBA_M_WD       6

`endif

// file: hdl/uiba_pkg.sv
// types shared by the uart interrupt bid arbiter
package uiba_pkg;
    typedef struct packed {
        logic [4:0] rx_cnt;
        logic       rx_err;
        logic [4:0] tx_empty;
        logic       brk_evt;
        logic       state_change_event;
        logic       xon_evt;
        logic       adr_evt;
        logic       wdog;
    } uiba_chan_t;

    typedef struct packed {
        logic       vld;
        logic [9:0] val;
    } uiba_bid_t;
endpackage : uiba_pkg

// file: hdl/uiba_bid_gen.sv
// per-channel bid builder
`timescale 1ns/1ns
`default_nettype none
`include "uiba_defines.svh"
module uiba_bid_gen (
    // channel state
    input  wire  uiba_pkg::uiba_chan_t            chan_i,
    input  wire  logic [2:0]                      chan_no_i,
    // configuration
    input  wire  logic [7:0]                      mask_i,
    input  wire  logic [11:0]                     bid_priority_regs_i,
    input  wire  logic [1:0]                      tx_bid_start_level_i,
    input  wire  logic [1:0]                      rx_bid_start_level_i,
    input  wire  logic                            wd_mode_i,
    // bids
    output var   uiba_pkg::uiba_bid_t [`UIBA_NSRC-1:0]  bid_o
);
    function automatic logic [4:0] lvl(input logic [1:0] sel);
        case (sel)
            2'h0:    lvl = `UIBA_LVL_ONE;
            2'h1:    lvl = `UIBA_LVL_HALF;
            2'h2:    lvl = `UIBA_LVL_3Q;
            default: lvl = `UIBA_LVL_FULL;
        endcase
    endfunction : lvl

    logic [4:0] rx_m1;
    logic [4:0] tx_m1;
    logic       rx_go;

    always_comb begin
        rx_m1 = chan_i.rx_cnt - `UIBA_LVL_ONE;
        tx_m1 = chan_i.tx_empty - `UIBA_LVL_ONE;
        // timeout drops the start level so a near-empty fifo still gets seen
        rx_go = wd_mode_i ? (chan_i.rx_cnt >= `UIBA_LVL_ONE)
                          : (chan_i.rx_cnt >= lvl(rx_bid_start_level_i));
        bid_o[0].val = {rx_m1[3:0], chan_i.rx_err ? `UIBA_ID_RXERR : `UIBA_ID_RXOK,
                        chan_no_i};
        bid_o[0].vld = mask_i[`UIBA_M_RX] && rx_go;
        bid_o[1].val = {1'b0, tx_m1[3:0], `UIBA_ID_TX, chan_no_i};
        bid_o[1].vld = mask_i[`UIBA_M_TX] && !wd_mode_i
                       && (chan_i.tx_empty >= lvl(tx_bid_start_level_i));
        bid_o[2].val = {bid_priority_regs_i[2:0], `UIBA_ID_BRK, chan_no_i};
        bid_o[2].vld = mask_i[`UIBA_M_BRK] && chan_i.brk_evt && !wd_mode_i;
        bid_o[3].val = {bid_priority_regs_i[5:3], `UIBA_ID_COS, chan_no_i};
        bid_o[3].vld = mask_i[`UIBA_M_COS] && chan_i.state_change_event && !wd_mode_i;
        bid_o[4].val = {bid_priority_regs_i[8:6], `UIBA_ID_XON, chan_no_i};
        bid_o[4].vld = mask_i[`UIBA_M_XON] && chan_i.xon_evt && !wd_mode_i;
        bid_o[5].val = {bid_priority_regs_i[11:9], `UIBA_ID_ADR, chan_no_i};
        bid_o[5].vld = mask_i[`UIBA_M_ADR] && chan_i.adr_evt && !wd_mode_i;
    end
endmodule : uiba_bid_gen
`default_nettype wire

// file: testbench/uiba_host_model.sv
// host cpu model answering the interrupt request line
`timescale 1ns/1ns
`default_nettype none
module uiba_host_model #(
    parameter int LATENCY = 3
) (
    // clock, reset, control
    input  wire  logic clk_i,
    input  wire  logic rst_n_i,
    input  wire  logic en_i,
    // handshake
    input  wire  logic req_n_i,
    output logic       ack_n_o
);
    int   cnt_ff = 0;
    logic ack_ff = 1'b1;

    assign ack_n_o = ack_ff;

    // slow answer: wait a few cycles, hold the ack low, then release
    always @(posedge clk_i) begin
        if (!rst_n_i || !en_i) begin
            cnt_ff <= 0;
            ack_ff <= 1'b1;
        end else if (cnt_ff == 0) begin
            if (!req_n_i) cnt_ff <= 1;
        end else if (cnt_ff < LATENCY) begin
            cnt_ff <= cnt_ff + 1;
        end else if (cnt_ff < LATENCY + 4) begin
            ack_ff <= 1'b0;
            cnt_ff <= cnt_ff + 1;
        end else begin
            ack_ff <= 1'b1;
            cnt_ff <= 0;
        end
    end
endmodule : uiba_host_model
`default_nettype wire

// file: testbench/test_uiba_arbiter.sv
// self-checking bench for the interrupt bid arbiter
`timescale 1ns/1ns
`default_nettype none
`include "uiba_defines.svh"
module test_uiba_arbiter;
    typedef struct packed {
        logic [1:0] ch;
        logic [4:0] rxc;
        logic       err;
        logic [4:0] txe;
        logic [4:0] ev;
        logic [1:0] lvl;
        logic [6:0] thr;
        logic [7:0] msk;
        logic [9:0] current_interrupt_latch;
    } uiba_row_t;

    logic                          mclk = 1'b0;
    logic                          ce = 1'b1;
    logic                          rst_n = 1'b0;
    logic [3:0]                    addr = 4'h0;
    logic [31:0]                   wdata = 32'h0;
    logic                          wr = 1'b0;
    logic                          rd = 1'b0;
    logic [31:0]                   rdata;
    uiba_pkg::uiba_chan_t [3:0]    chan = '0;
    uiba_pkg::uiba_chan_t [3:0]    tmp;
    logic                          ack_n;
    logic                          irq_n;
    logic                          host_en = 1'b0;
    logic [9:0]                    current_interrupt_latch;
    logic [3:0]                    cir_type;
    logic [2:0]                    cir_chan;
    logic [31:0]                   d;
    uiba_row_t                     r;
    int                            n_mismatch = 0;
    int                            num_checks = 0;
    int                            cycles = 0;
    // expected bids worked out by hand; event priorities 1,2,3,4 below
    uiba_row_t rows [16] = '{
        '{2'd2, 5'h01, 1'b0, 5'h00, 5'h00, 2'h0, 7'h00, 8'h01, 10'h00A},
        '{2'd1, 5'h10, 1'b1, 5'h00, 5'h00, 2'h0, 7'h00, 8'h01, 10'h3E9},
        '{2'd3, 5'h00, 1'b0, 5'h10, 5'h00, 2'h0, 7'h00, 8'h02, 10'h1E3},
        '{2'd3, 5'h00, 1'b0, 5'h10, 5'h00, 2'h0, 7'h40, 8'h02, 10'h000},
        '{2'd0, 5'h10, 1'b0, 5'h10, 5'h00, 2'h0, 7'h40, 8'h03, 10'h3C8},
        '{2'd3, 5'h00, 1'b0, 5'h01, 5'h00, 2'h0, 7'h00, 8'h02, 10'h003},
        '{2'd3, 5'h00, 1'b0, 5'h01, 5'h00, 2'h0, 7'h01, 8'h02, 10'h000},
        '{2'd0, 5'h00, 1'b0, 5'h00, 5'h10, 2'h0, 7'h00, 8'h04, 10'h090},
        '{2'd1, 5'h00, 1'b0, 5'h00, 5'h08, 2'h0, 7'h00, 8'h08, 10'h131},
        '{2'd2, 5'h00, 1'b0, 5'h00, 5'h04, 2'h0, 7'h00, 8'h10, 10'h1BA},
        '{2'd3, 5'h00, 1'b0, 5'h00, 5'h02, 2'h0, 7'h00, 8'h20, 10'h21B},
        '{2'd0, 5'h10, 1'b0, 5'h00, 5'h00, 2'h0, 7'h00, 8'h3E, 10'h000},
        '{2'd2, 5'h01, 1'b0, 5'h00, 5'h00, 2'h0, 7'h02, 8'h01, 10'h000},
        '{2'd1, 5'h07, 1'b0, 5'h00, 5'h00, 2'h1, 7'h00, 8'h01, 10'h000},
        '{2'd1, 5'h08, 1'b0, 5'h00, 5'h00, 2'h1, 7'h00, 8'h01, 10'h1C9},
        '{2'd0, 5'h01, 1'b0, 5'h00, 5'h11, 2'h0, 7'h7F, 8'h45, 10'h008}
    };

    initial begin
        forever #20 mclk = ~mclk;
    end

    uiba_arbiter u_uiba_arbiter (
        .MCLK_I                  (mclk),
        .RST_N_I                 (rst_n),
        .CE_I                    (ce),
        .ADDR_I                  (addr),
        .WDATA_I                 (wdata),
        .WR_I                    (wr),
        .RD_I                    (rd),
        .RDATA_O                 (rdata),
        .CHAN_STAT_I             (chan),
        .INTERRUPT_ACK_LOW_I     (ack_n),
        .INTERRUPT_REQUEST_LOW_O (irq_n),
        .CIR_O                   (current_interrupt_latch),
        .CIR_TYPE_O              (cir_type),
        .CIR_CHAN_O              (cir_chan)
    );

    uiba_host_model u_uiba_host_model (
        .clk_i   (mclk),
        .rst_n_i (rst_n),
        .en_i    (host_en),
        .req_n_i (irq_n),
        .ack_n_o (ack_n)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // a hang costs one mismatch and ends the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk("request after reset", 32'h1, {31'h0, irq_n});
        reg_rd(`UIBA_A_CIR, d);
        chk("cir after reset", 32'h0, d);
        reg_rd(4'hF, d);
        chk("unmapped read", 32'h0, d);
        reg_wr(`UIBA_A_BPR, 32'h0000_08D1);
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            reg_wr(`UIBA_A_ICR, {25'h0, r.thr});
            reg_wr(`UIBA_A_IMR, {24'h0, r.msk} << (8 * r.ch));
            reg_wr(`UIBA_A_MR0, {30'h0, r.lvl} << (2 * r.ch));
            reg_wr(`UIBA_A_MR2, {30'h0, r.lvl} << (2 * r.ch));
            tmp = '0;
            tmp[r.ch].rx_cnt = r.rxc;
            tmp[r.ch].rx_err = r.err;
            tmp[r.ch].tx_empty = r.txe;
            {tmp[r.ch].brk_evt, tmp[r.ch].state_change_event, tmp[r.ch].xon_evt,
             tmp[r.ch].adr_evt, tmp[r.ch].wdog} = r.ev;
            @(posedge mclk);
            chan <= tmp;
            // two whole scans so the snapshot surely holds the new state
            repeat (46) @(posedge mclk);
            reg_wr(`UIBA_A_CIR, 32'h0);
            reg_rd(`UIBA_A_CIR, d);
            chk("row cir", {22'h0, r.current_interrupt_latch}, d);
            chk("row request", {31'h0, r.current_interrupt_latch == 10'h000}, {31'h0, irq_n});
        end
        reg_rd(`UIBA_A_ICR, d);
        chk("threshold readback", 32'h7F, d);
        // equal receivers on channels 0 and 3, host acknowledges
        reg_wr(`UIBA_A_ICR, 32'h0);
        reg_wr(`UIBA_A_IMR, 32'h0100_0001);
        reg_wr(`UIBA_A_MR0, 32'h0);
        reg_wr(`UIBA_A_MR2, 32'h0);
        tmp = '0;
        tmp[0].rx_cnt = 5'h04;
        tmp[3].rx_cnt = 5'h04;
        @(posedge mclk);
        chan <= tmp;
        repeat (46) @(posedge mclk);
        host_en <= 1'b1;
        for (int k = 0; k < 100 && ack_n !== 1'b0; k++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        #1;
        chk("ack cir", 32'h0CB, {22'h0, current_interrupt_latch});
        chk("ack type", 32'h9, {28'h0, cir_type});
        chk("ack chan", 32'h3, {29'h0, cir_chan});
        reg_rd(`UIBA_A_STAT, d);
        chk("status", 32'h3, d);
        @(posedge mclk);
        host_en <= 1'b0;
        chan <= '0;
        repeat (46) @(posedge mclk);
        #1;
        chk("request withdrawn", 32'h1, {31'h0, irq_n});
        reg_wr(`UIBA_A_CIR, 32'h0);
        @(posedge mclk);
        #1;
        chk("cir no winner", 32'h0, {22'h0, current_interrupt_latch});
        // enable low must swallow a register write
        @(posedge mclk);
        ce <= 1'b0;
        reg_wr(`UIBA_A_ICR, 32'h0000_0055);
        @(posedge mclk);
        ce <= 1'b1;
        reg_rd(`UIBA_A_ICR, d);
        chk("frozen write", 32'h0, d);
        complete_run();
    end
endmodule : test_uiba_arbiter
`default_nettype wire
